// ===== design/fdsm_consts.svh
// register indices, reset values and field positions of the fast-detect and
// signal-monitor sync block; assumes byte address = 4 * index on the bus
`ifndef FDSM_CONSTS_SVH
`define FDSM_CONSTS_SVH

`define FDSM_IDX_FD_CTRL     10'h245
`define FDSM_IDX_UPPER_LO    10'h247
`define FDSM_IDX_UPPER_HI    10'h248
`define FDSM_IDX_LOWER_LO    10'h249
`define FDSM_IDX_LOWER_HI    10'h24a
`define FDSM_IDX_DWELL_LO    10'h24b
`define FDSM_IDX_DWELL_HI    10'h24c
`define FDSM_IDX_SYNC_CTRL   10'h26f
`define FDSM_IDX_PERIOD0     10'h271
`define FDSM_IDX_PERIOD1     10'h272
`define FDSM_IDX_PERIOD2     10'h273
`define FDSM_IDX_SYSREF_CTRL 10'h2a0
`define FDSM_IDX_STATUS      10'h2a1

`define FDSM_RST_BYTE        8'h00
`define FDSM_RST_WORD        32'h00000000
`define FDSM_RST_HI5         5'h00
`define FDSM_RST_PERIOD0     8'h80
`define FDSM_RST_DWELL_CNT   16'h0000
`define FDSM_RST_PERIOD_CNT  24'h000000

`define FDSM_BIT_FD_EN       0
`define FDSM_BIT_NEXT_SYNC   1
`define FDSM_BIT_SYSREF_EN   0
`define FDSM_HI_MSB          4
`define FDSM_MIN_PERIOD      24'h000002
`define FDSM_ONE16           16'h0001
`define FDSM_ONE24           24'h000001

`endif

// ===== design/fdsm_pkg.sv
// types shared by the fast-detect and signal-monitor sync modules
// assumes nothing beyond a SystemVerilog compiler
package fdsm_pkg;
  typedef logic [12:0] fdsm_thresh_type;
  typedef logic [15:0] fdsm_dwell_type;
  typedef logic [23:0] fdsm_period_type;
  typedef enum logic [1:0] {
    FDSM_SYNC_CONT  = 2'b00,
    FDSM_SYNC_ARMED = 2'b01,
    FDSM_SYNC_DONE  = 2'b10
  } fdsm_sync_state_type;
endpackage

// ===== design/fdsm_cfg_if.sv
// configuration and event bundle between the register file and the
// comparator and monitor modules; all on one clock
`timescale 1ns/1ps
interface fdsm_cfg_if;
  fdsm_pkg::fdsm_thresh_type upper;
  fdsm_pkg::fdsm_thresh_type lower;
  fdsm_pkg::fdsm_dwell_type  dwell;
  logic                      fd_enable;
  fdsm_pkg::fdsm_period_type period;
  logic                      sync_pulse;
  logic                      period_end;

  modport regs (output upper, output lower, output dwell, output fd_enable,
                output period, output sync_pulse, input period_end);
  modport flag (input upper, input lower, input dwell, input fd_enable);
  modport mon  (input period, input sync_pulse, output period_end);
endinterface

// ===== design/fdsm_flag.sv
// fast-detect comparator for one channel with the dwell counter
// assumes one magnitude sample per clock, synchronous to the clock
`timescale 1ns/1ps
`include "fdsm_consts.svh"
module fdsm_flag (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  fdsm_cfg_if.flag                       cfg,
  input  wire fdsm_pkg::fdsm_thresh_type magnitude,
  output logic                           flag_out
);
  fdsm_pkg::fdsm_dwell_type dwell_cnt_reg;
  logic                     flag_reg;
  logic                     above_upper;
  logic                     above_lower;

  assign above_upper = magnitude > cfg.upper;
  assign above_lower = magnitude >= cfg.lower;
  assign flag_out    = flag_reg;

  // dwell counter: reloaded while at or above the lower threshold or while the flag is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_cnt_reg <= `FDSM_RST_DWELL_CNT;
    end else if (above_lower || !flag_reg) begin
      dwell_cnt_reg <= cfg.dwell;
    end else if (dwell_cnt_reg > `FDSM_ONE16) begin
      dwell_cnt_reg <= dwell_cnt_reg - `FDSM_ONE16;
    end
  end

  // flag: set above upper, cleared once the dwell count has run out or while fd_enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (!cfg.fd_enable) begin
      flag_reg <= 1'b0;
    end else if (above_upper) begin
      flag_reg <= 1'b1;
    end else if (flag_reg && !above_lower && dwell_cnt_reg <= `FDSM_ONE16) begin
      flag_reg <= 1'b0;
    end
  end
endmodule

// ===== design/fdsm_period.sv
// signal-monitor period counter; a sync pulse restarts the period
// assumes the period value is stable between software writes
`timescale 1ns/1ps
`include "fdsm_consts.svh"
module fdsm_period (
  input  wire logic clk,
  input  wire logic rst_n,
  fdsm_cfg_if.mon   cfg
);
  fdsm_pkg::fdsm_period_type cnt_reg;
  fdsm_pkg::fdsm_period_type even_period;
  fdsm_pkg::fdsm_period_type last_count;
  logic                      period_end_reg;

  // odd values are unsupported; the low bit is dropped, and tiny values
  // are lifted to the smallest even period so the counter never stalls
  always_comb begin
    even_period = {cfg.period[23:1], 1'b0};
    if (even_period < `FDSM_MIN_PERIOD) begin
      even_period = `FDSM_MIN_PERIOD;
    end
    last_count = even_period - `FDSM_ONE24;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `FDSM_RST_PERIOD_CNT;
    end else if (cfg.sync_pulse || cnt_reg >= last_count) begin
      cnt_reg <= `FDSM_RST_PERIOD_CNT;
    end else begin
      cnt_reg <= cnt_reg + `FDSM_ONE24;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_end_reg <= 1'b0;
    end else begin
      period_end_reg <= !cfg.sync_pulse && cnt_reg >= last_count;
    end
  end

  assign cfg.period_end = period_end_reg;
endmodule

// ===== design/fdsm_top.sv
// fast-detect thresholds, dwell, signal-monitor period and sync control
// behind an APB slave; SYSREF and magnitudes are synchronous to CLOCK
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "fdsm_consts.svh"
module fdsm_top (
  input  wire logic                      CLOCK,
  input  wire logic                      RST_N,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [11:0]               PADDR,
  input  wire logic [31:0]               PWDATA,
  input  wire logic [3:0]                PSTRB,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic                      SYSREF,
  input  wire fdsm_pkg::fdsm_thresh_type MAG_FIRST,
  input  wire fdsm_pkg::fdsm_thresh_type MAG_SECOND,
  output logic                           THRESHOLD_FLAG_OUTPUT_FIRST,
  output logic                           THRESHOLD_FLAG_OUTPUT_SECOND,
  output logic                           MONITOR_SYNC,
  output logic                           MONITOR_PERIOD_END
);
  fdsm_cfg_if cfg ();

  logic [7:0]                    fd_ctrl_reg;
  logic [7:0]                    upper_lo_reg;
  logic [4:0]                    upper_hi_reg;
  logic [7:0]                    lower_lo_reg;
  logic [4:0]                    lower_hi_reg;
  logic [7:0]                    dwell_lo_reg;
  logic [7:0]                    dwell_hi_reg;
  logic [7:0]                    period0_reg;
  logic [7:0]                    period1_reg;
  logic [7:0]                    period2_reg;
  logic                          sysref_en_reg;
  fdsm_pkg::fdsm_sync_state_type sync_state_reg;
  fdsm_pkg::fdsm_sync_state_type sync_state_next;
  logic                          sysref_dly_reg;
  logic                          sync_pulse_reg;
  logic                          sync_fire;
  logic                          sysref_edge;
  logic [31:0]                   prdata_reg;
  logic [31:0]                   rd_next;
  logic [9:0]                    index;
  logic                          access;
  logic                          wr_en;
  logic                          flag_first;
  logic                          flag_second;

  function automatic logic is_mapped(input logic [9:0] idx);
    case (idx)
      `FDSM_IDX_FD_CTRL, `FDSM_IDX_UPPER_LO, `FDSM_IDX_UPPER_HI,
      `FDSM_IDX_LOWER_LO, `FDSM_IDX_LOWER_HI, `FDSM_IDX_DWELL_LO,
      `FDSM_IDX_DWELL_HI, `FDSM_IDX_SYNC_CTRL, `FDSM_IDX_PERIOD0,
      `FDSM_IDX_PERIOD1, `FDSM_IDX_PERIOD2, `FDSM_IDX_SYSREF_CTRL,
      `FDSM_IDX_STATUS: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  // write strobe for one register; only the low byte lane carries data
  function automatic logic wr_hit(input logic en, input logic [9:0] idx,
                                  input logic [9:0] target);
    wr_hit = en && (idx == target);
  endfunction

  // zero-wait slave: every access completes in its first access cycle
  assign index   = PADDR[11:2];
  assign access  = PSEL && PENABLE;
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !is_mapped(index);
  assign wr_en   = access && PWRITE && PSTRB[0] && is_mapped(index);
  assign PRDATA  = prdata_reg;

  // fast-detect enable; other control bits are stored but unused here
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fd_ctrl_reg <= `FDSM_RST_BYTE;
    end else if (wr_hit(wr_en, index, `FDSM_IDX_FD_CTRL)) begin
      fd_ctrl_reg <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      upper_lo_reg <= `FDSM_RST_BYTE;
      upper_hi_reg <= `FDSM_RST_HI5;
    end else begin
      if (wr_hit(wr_en, index, `FDSM_IDX_UPPER_LO)) begin
        upper_lo_reg <= PWDATA[7:0];
      end
      if (wr_hit(wr_en, index, `FDSM_IDX_UPPER_HI)) begin
        upper_hi_reg <= PWDATA[`FDSM_HI_MSB:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lower_lo_reg <= `FDSM_RST_BYTE;
      lower_hi_reg <= `FDSM_RST_HI5;
    end else begin
      if (wr_hit(wr_en, index, `FDSM_IDX_LOWER_LO)) begin
        lower_lo_reg <= PWDATA[7:0];
      end
      if (wr_hit(wr_en, index, `FDSM_IDX_LOWER_HI)) begin
        lower_hi_reg <= PWDATA[`FDSM_HI_MSB:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dwell_lo_reg <= `FDSM_RST_BYTE;
      dwell_hi_reg <= `FDSM_RST_BYTE;
    end else begin
      if (wr_hit(wr_en, index, `FDSM_IDX_DWELL_LO)) begin
        dwell_lo_reg <= PWDATA[7:0];
      end
      if (wr_hit(wr_en, index, `FDSM_IDX_DWELL_HI)) begin
        dwell_hi_reg <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      period0_reg <= `FDSM_RST_PERIOD0;
      period1_reg <= `FDSM_RST_BYTE;
      period2_reg <= `FDSM_RST_BYTE;
    end else begin
      if (wr_hit(wr_en, index, `FDSM_IDX_PERIOD0)) begin
        period0_reg <= PWDATA[7:0];
      end
      if (wr_hit(wr_en, index, `FDSM_IDX_PERIOD1)) begin
        period1_reg <= PWDATA[7:0];
      end
      if (wr_hit(wr_en, index, `FDSM_IDX_PERIOD2)) begin
        period2_reg <= PWDATA[7:0];
      end
    end
  end

  // no edge reaches the monitor until software opens the reference input
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sysref_en_reg <= 1'b0;
    end else if (wr_hit(wr_en, index, `FDSM_IDX_SYSREF_CTRL)) begin
      sysref_en_reg <= PWDATA[`FDSM_BIT_SYSREF_EN];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sysref_dly_reg <= 1'b0;
    end else begin
      sysref_dly_reg <= SYSREF;
    end
  end

  assign sysref_edge = SYSREF && !sysref_dly_reg && sysref_en_reg;

  // sync state: a software write to the control register always wins,
  // so re-arming in the same cycle as an edge is never lost
  always_comb begin
    sync_state_next = sync_state_reg;
    sync_fire       = 1'b0;
    if (wr_hit(wr_en, index, `FDSM_IDX_SYNC_CTRL)) begin
      if (PWDATA[`FDSM_BIT_NEXT_SYNC]) begin
        sync_state_next = fdsm_pkg::FDSM_SYNC_ARMED;
      end else begin
        sync_state_next = fdsm_pkg::FDSM_SYNC_CONT;
      end
    end else begin
      case (sync_state_reg)
        fdsm_pkg::FDSM_SYNC_CONT: begin
          sync_fire = sysref_edge;
        end
        fdsm_pkg::FDSM_SYNC_ARMED: begin
          if (sysref_edge) begin
            sync_fire       = 1'b1;
            sync_state_next = fdsm_pkg::FDSM_SYNC_DONE;
          end
        end
        fdsm_pkg::FDSM_SYNC_DONE: begin
          sync_fire = 1'b0;
        end
        default: begin
          sync_state_next = fdsm_pkg::FDSM_SYNC_CONT;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync_state_reg <= fdsm_pkg::FDSM_SYNC_CONT;
    end else begin
      sync_state_reg <= sync_state_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync_pulse_reg <= 1'b0;
    end else begin
      sync_pulse_reg <= sync_fire;
    end
  end

  // read mux; reserved bits come back as zero
  always_comb begin
    rd_next = 32'h00000000;
    case (index)
      `FDSM_IDX_FD_CTRL:     rd_next[7:0] = fd_ctrl_reg;
      `FDSM_IDX_UPPER_LO:    rd_next[7:0] = upper_lo_reg;
      `FDSM_IDX_UPPER_HI:    rd_next[`FDSM_HI_MSB:0] = upper_hi_reg;
      `FDSM_IDX_LOWER_LO:    rd_next[7:0] = lower_lo_reg;
      `FDSM_IDX_LOWER_HI:    rd_next[`FDSM_HI_MSB:0] = lower_hi_reg;
      `FDSM_IDX_DWELL_LO:    rd_next[7:0] = dwell_lo_reg;
      `FDSM_IDX_DWELL_HI:    rd_next[7:0] = dwell_hi_reg;
      `FDSM_IDX_SYNC_CTRL: begin
        rd_next[`FDSM_BIT_NEXT_SYNC] = (sync_state_reg == fdsm_pkg::FDSM_SYNC_ARMED);
      end
      `FDSM_IDX_PERIOD0:     rd_next[7:0] = period0_reg;
      `FDSM_IDX_PERIOD1:     rd_next[7:0] = period1_reg;
      `FDSM_IDX_PERIOD2:     rd_next[7:0] = period2_reg;
      `FDSM_IDX_SYSREF_CTRL: rd_next[`FDSM_BIT_SYSREF_EN] = sysref_en_reg;
      `FDSM_IDX_STATUS: begin
        rd_next[2:0] = {sync_state_reg == fdsm_pkg::FDSM_SYNC_DONE, flag_second, flag_first};
      end
      default: begin
        rd_next = 32'h00000000;
      end
    endcase
  end

  // read data is captured in the setup cycle and held through the access
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_reg <= `FDSM_RST_WORD;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_reg <= rd_next;
    end
  end

  assign cfg.upper      = {upper_hi_reg, upper_lo_reg};
  assign cfg.lower      = {lower_hi_reg, lower_lo_reg};
  assign cfg.dwell      = {dwell_hi_reg, dwell_lo_reg};
  assign cfg.fd_enable  = fd_ctrl_reg[`FDSM_BIT_FD_EN];
  assign cfg.period     = {period2_reg, period1_reg, period0_reg};
  assign cfg.sync_pulse = sync_pulse_reg;

  fdsm_flag u_flag_first (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .cfg       (cfg),
    .magnitude (MAG_FIRST),
    .flag_out  (flag_first)
  );

  fdsm_flag u_flag_second (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .cfg       (cfg),
    .magnitude (MAG_SECOND),
    .flag_out  (flag_second)
  );

  fdsm_period u_period (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .cfg   (cfg)
  );

  assign THRESHOLD_FLAG_OUTPUT_FIRST  = flag_first;
  assign THRESHOLD_FLAG_OUTPUT_SECOND = flag_second;
  assign MONITOR_SYNC                 = sync_pulse_reg;
  assign MONITOR_PERIOD_END           = cfg.period_end;
endmodule

// ===== bench/fdsm_top_props.sv
// assertions on the ports of the fast-detect and monitor sync block
// assumes a write lands at the access edge with strobe bit 0 set
`timescale 1ns/1ps
`include "fdsm_consts.svh"
module fdsm_props (
  input wire logic                      CLOCK,
  input wire logic                      RST_N,
  input wire logic                      PSEL,
  input wire logic                      PENABLE,
  input wire logic                      PWRITE,
  input wire logic [11:0]               PADDR,
  input wire logic [31:0]               PWDATA,
  input wire logic [3:0]                PSTRB,
  input wire logic [31:0]               PRDATA,
  input wire logic                      PREADY,
  input wire logic                      PSLVERR,
  input wire logic                      SYSREF,
  input wire fdsm_pkg::fdsm_thresh_type MAG_FIRST,
  input wire fdsm_pkg::fdsm_thresh_type MAG_SECOND,
  input wire logic                      THRESHOLD_FLAG_OUTPUT_FIRST,
  input wire logic                      THRESHOLD_FLAG_OUTPUT_SECOND,
  input wire logic                      MONITOR_SYNC,
  input wire logic                      MONITOR_PERIOD_END
);
  logic                      en_m;
  fdsm_pkg::fdsm_thresh_type up_m;
  fdsm_pkg::fdsm_thresh_type lo_m;
  logic                      wr;
  logic [9:0]                idx;
  assign wr  = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign idx = PADDR[11:2];
  // mirrors kept from bus writes, so flag checks need no hierarchy
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      en_m <= 1'b0;
      up_m <= '0;
      lo_m <= '0;
    end else if (wr) begin
      if (idx == `FDSM_IDX_FD_CTRL) en_m <= PWDATA[0];
      if (idx == `FDSM_IDX_UPPER_LO) up_m[7:0] <= PWDATA[7:0];
      if (idx == `FDSM_IDX_UPPER_HI) up_m[12:8] <= PWDATA[4:0];
      if (idx == `FDSM_IDX_LOWER_LO) lo_m[7:0] <= PWDATA[7:0];
      if (idx == `FDSM_IDX_LOWER_HI) lo_m[12:8] <= PWDATA[4:0];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_set1; en_m && MAG_FIRST > up_m |=> THRESHOLD_FLAG_OUTPUT_FIRST; endproperty
  property p_set2; en_m && MAG_SECOND > up_m |=> THRESHOLD_FLAG_OUTPUT_SECOND; endproperty
  property p_hold;
    en_m && THRESHOLD_FLAG_OUTPUT_FIRST && MAG_FIRST >= lo_m |=> THRESHOLD_FLAG_OUTPUT_FIRST;
  endproperty
  property p_fall;
    $fell(THRESHOLD_FLAG_OUTPUT_FIRST) |-> !$past(en_m) || $past(MAG_FIRST) < $past(lo_m);
  endproperty
  property p_off; !en_m [*2] |-> !THRESHOLD_FLAG_OUTPUT_FIRST; endproperty
  property p_cause; MONITOR_SYNC |-> $past(SYSREF) && !$past(SYSREF, 2); endproperty
  property p_sync1; MONITOR_SYNC |=> !MONITOR_SYNC; endproperty
  property p_end1; MONITOR_PERIOD_END |=> !MONITOR_PERIOD_END; endproperty
  a_set1: assert property (p_set1) else $error("flag 1 not set");
  a_set2: assert property (p_set2) else $error("flag 2 not set");
  a_hold: assert property (p_hold) else $error("flag dropped at level");
  a_fall: assert property (p_fall) else $error("flag dropped early");
  a_off: assert property (p_off) else $error("flag high while off");
  a_cause: assert property (p_cause) else $error("sync without edge");
  a_sync1: assert property (p_sync1) else $error("sync pulse too long");
  a_end1: assert property (p_end1) else $error("end pulse too long");
  c_sync: cover property (MONITOR_SYNC);
  c_fall: cover property ($fell(THRESHOLD_FLAG_OUTPUT_FIRST));
  c_end: cover property (MONITOR_PERIOD_END);
endmodule
bind fdsm_top fdsm_props u_props (.CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PSTRB, .PRDATA, .PREADY, .PSLVERR, .SYSREF, .MAG_FIRST, .MAG_SECOND,
  .THRESHOLD_FLAG_OUTPUT_FIRST, .THRESHOLD_FLAG_OUTPUT_SECOND, .MONITOR_SYNC,
  .MONITOR_PERIOD_END);

// ===== bench/fdsm_sysref_gen.sv
// reference generator model: one two-cycle pulse per request
// assumes the bench asks for pulses no closer than the monitor period
`timescale 1ns/1ps
module fdsm_sysref_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fire,
  input  wire logic [3:0] lag,
  output logic            sysref
);
  logic [4:0] cnt_reg;
  logic [1:0] phase_reg;
  // rises only land when this phase wraps, so any two rises lie a multiple
  // of four cycles apart, the monitor period that the bench programs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  // lag varies the answer from prompt to slow; line is low between pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
    end else if (fire) begin
      cnt_reg <= {1'b0, lag} + 5'h03;
    end else if (cnt_reg != 5'h00 && (cnt_reg != 5'h03 || phase_reg == 2'h3)) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
  assign sysref = (cnt_reg == 5'h01) || (cnt_reg == 5'h02);
endmodule

// ===== bench/tb_fdsm_top.sv
// self-checking bench for the fast-detect and monitor sync block
// assumes zero-wait APB and a reference synchronous to CLOCK
`timescale 1ns/1ps
`include "fdsm_consts.svh"
module tb_fdsm_top;
  logic                      CLOCK = 1'b0;
  logic                      RST_N = 1'b0;
  logic                      PSEL = 1'b0;
  logic                      PENABLE = 1'b0;
  logic                      PWRITE = 1'b0;
  logic [11:0]               PADDR = 12'h000;
  logic [31:0]               PWDATA = 32'h0;
  logic [3:0]                PSTRB = 4'hf;
  logic [31:0]               PRDATA;
  logic                      PREADY;
  logic                      PSLVERR;
  logic                      SYSREF;
  fdsm_pkg::fdsm_thresh_type MAG_FIRST = '0;
  fdsm_pkg::fdsm_thresh_type MAG_SECOND = '0;
  logic                      THRESHOLD_FLAG_OUTPUT_FIRST;
  logic                      THRESHOLD_FLAG_OUTPUT_SECOND;
  logic                      MONITOR_SYNC;
  logic                      MONITOR_PERIOD_END;
  logic                      fire = 1'b0;
  logic [3:0]                lag = 4'h0;
  int                        bad_count = 0;
  int                        comparisons = 0;
  int                        cyc = 0;
  always #5 CLOCK = ~CLOCK;
  fdsm_top dut (.CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
    .PREADY, .PSLVERR, .SYSREF, .MAG_FIRST, .MAG_SECOND, .THRESHOLD_FLAG_OUTPUT_FIRST,
    .THRESHOLD_FLAG_OUTPUT_SECOND, .MONITOR_SYNC, .MONITOR_PERIOD_END);
  fdsm_sysref_gen gen (.clk(CLOCK), .rst_n(RST_N), .fire(fire), .lag(lag), .sysref(SYSREF));
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, exp, "read data");
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rd(`FDSM_IDX_LOWER_LO, 32'h0);
    rd(`FDSM_IDX_LOWER_HI, 32'h0);
    rd(`FDSM_IDX_DWELL_LO, 32'h0);
    rd(`FDSM_IDX_DWELL_HI, 32'h0);
    rd(`FDSM_IDX_SYNC_CTRL, 32'h0);
    rd(`FDSM_IDX_PERIOD0, 32'h80);
    // a write without the low byte strobe must leave the register alone
    PSTRB <= 4'he;
    wr(`FDSM_IDX_LOWER_LO, 8'h77);
    PSTRB <= 4'hf;
    rd(`FDSM_IDX_LOWER_LO, 32'h0);
    wr(`FDSM_IDX_LOWER_HI, 8'hff);
    rd(`FDSM_IDX_LOWER_HI, 32'h1f);
    wr(`FDSM_IDX_SYNC_CTRL, 8'hfd);
    rd(`FDSM_IDX_SYNC_CTRL, 32'h0);
    apb(1'b1, 10'h000, 8'h5a, r, e);
    chk(e, 32'h1, "unmapped error");
  endtask
  task automatic t_flag;
    int n;
    wr(`FDSM_IDX_FD_CTRL, 8'h01);
    wr(`FDSM_IDX_UPPER_LO, 8'h64);
    wr(`FDSM_IDX_LOWER_LO, 8'h32);
    wr(`FDSM_IDX_LOWER_HI, 8'h00);
    wr(`FDSM_IDX_DWELL_LO, 8'h03);
    wr(`FDSM_IDX_DWELL_HI, 8'h01);
    MAG_SECOND <= 13'h004b;
    MAG_FIRST <= 13'h00c8;
    @(posedge CLOCK);
    MAG_FIRST <= 13'h000a;
    repeat (40) @(posedge CLOCK);
    chk(THRESHOLD_FLAG_OUTPUT_FIRST, 32'h1, "flag during dwell");
    MAG_FIRST <= 13'h0032;
    @(posedge CLOCK);
    MAG_FIRST <= 13'h000a;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (THRESHOLD_FLAG_OUTPUT_FIRST === 1'b1 && n < 400);
    chk(n, 32'd260, "dwell cycles");
    chk(THRESHOLD_FLAG_OUTPUT_SECOND, 32'h0, "flag between limits");
    MAG_FIRST <= 13'h00c8;
    MAG_SECOND <= 13'h00c8;
    wr(`FDSM_IDX_FD_CTRL, 8'h00);
    repeat (2) @(posedge CLOCK);
    chk(THRESHOLD_FLAG_OUTPUT_FIRST, 32'h0, "flag when disabled");
    chk(THRESHOLD_FLAG_OUTPUT_SECOND, 32'h0, "flag 2 when disabled");
  endtask
  task automatic pulse(input int exp_n);
    int seen;
    seen = 0;
    @(posedge CLOCK);
    fire <= 1'b1;
    lag <= lag + 4'h7;
    @(posedge CLOCK);
    fire <= 1'b0;
    repeat (24) begin
      @(posedge CLOCK);
      if (MONITOR_SYNC === 1'b1) seen++;
    end
    chk(seen, exp_n, "sync pulses");
  endtask
  task automatic gap(input int exp_n);
    int n;
    n = 0;
    while (MONITOR_PERIOD_END !== 1'b1 && n < 50) begin
      @(posedge CLOCK);
      n++;
    end
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (MONITOR_PERIOD_END !== 1'b1 && n < 50);
    chk(n, exp_n, "period spacing");
  endtask
  task automatic t_sync;
    wr(`FDSM_IDX_PERIOD0, 8'h04);
    pulse(0);
    wr(`FDSM_IDX_SYSREF_CTRL, 8'h01);
    pulse(1);
    pulse(1);
    gap(4);
    // odd periods are unsupported: the low bit is dropped
    wr(`FDSM_IDX_PERIOD0, 8'h05);
    gap(4);
    wr(`FDSM_IDX_SYNC_CTRL, 8'h02);
    rd(`FDSM_IDX_SYNC_CTRL, 32'h2);
    pulse(1);
    rd(`FDSM_IDX_SYNC_CTRL, 32'h0);
    rd(`FDSM_IDX_STATUS, 32'h4);
    pulse(0);
  endtask
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    // the whole run needs under 2000 cycles
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_regs();
    t_flag();
    t_sync();
    print_verdict();
  end
endmodule
